// [rtl/mem_consts.vh]
// Constants shared by the motion event manager design files
// How it works
// - Two timers, three compare, capture, decoder, interrupts
// - Timer mode is a two-bit field
// - No single up or up/down counting modes
// - No cascaded 32-bit timer mode exists
// - Directional counting reverses at period, ffff, 0000
// - Third capture event can start converter
// - Captures use timer 2 or timer 1
// - Capture flag sets only if queue nonempty
// - Queue status writable; bits 5-0 reserved
// - Each queue entry readable on its own
// - Quadrature decoder clocks timer 2 only
// - Compare units run PWM mode only
// - Dead-band counter 4 bits, prescaler 5 bits
// - Prescale selects at control bits 2..4
// - Bits of removed functions are reserved
// - One request line, enable per flag
// - Flag clears only on write of one
// - Reading vector id leaves flags alone
// - Drive fault interrupt enabled after reset
// - One write fully sets compare control
// - Fault low sets flag, tristates outputs when fault unmasked
// - Undefined registers and bits read zero
// - Decode low six address bits in frame
// - Request raised when flag and mask set
`ifndef MEM_CONSTS_VH
`define MEM_CONSTS_VH
// ----------------------------------------
// Register offsets (low six address bits)
// ----------------------------------------
`define MEM_A_TCON 6'h00
`define MEM_A_T1CNT 6'h01
`define MEM_A_T1CMP 6'h02
`define MEM_A_T1PR 6'h03
`define MEM_A_T1CTL 6'h04
`define MEM_A_T2CNT 6'h05
`define MEM_A_T2CMP 6'h06
`define MEM_A_T2PR 6'h07
`define MEM_A_T2CTL 6'h08
`define MEM_A_CMPCTL 6'h11
`define MEM_A_CMP1 6'h17
`define MEM_A_CMP2 6'h18
`define MEM_A_CMP3 6'h19
`define MEM_A_DBCTL 6'h15
`define MEM_A_CAPCTL 6'h20
`define MEM_A_CAPQ 6'h22
`define MEM_A_CAPE0 6'h23
`define MEM_A_CAPE1 6'h24
`define MEM_A_IFLAG 6'h2f
`define MEM_A_IMASK 6'h2c
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define MEM_MODE_STOP 2'h0
`define MEM_MODE_CONT_UP 2'h1
`define MEM_MODE_CONT_UD 2'h2
`define MEM_MODE_DIR_UD 2'h3
`define MEM_T_MODE_LSB 11
`define MEM_T_EN_BIT 6
`define MEM_T_QEP_BIT 4
`define MEM_DB_PS_LSB 2
`define MEM_DB_CNT_LSB 8
`define MEM_CMP_EN_BIT 15
`define MEM_CAP_TB_BIT 0
`define MEM_CAP_ADC_BIT 1
`define MEM_FLAG_FAULT 0
`define MEM_FLAG_CAP0 5
`define MEM_IMASK_RST 8'h01
`define MEM_FAULT_CYC 2
`endif

// [rtl/mem_capture_queue.v]
// Two-entry capture queue for one capture input
`timescale 1ns/1ps
`default_nettype none
module mem_capture_queue #(
  parameter W = 16
) (
  input wire clk,
  input wire rst,
  input wire cap_evt,
  input wire [W-1:0] stamp,
  input wire pop,
  input wire st_we,
  input wire [1:0] st_wdata,
  output reg [1:0] status_reg,
  output reg [W-1:0] ent0_reg,
  output reg [W-1:0] ent1_reg,
  output reg flag_set
);
  // ----------------------------------------
  // Queue storage
  // ----------------------------------------
  // Store in arrival order, newest drops oldest when full
  always @(posedge clk) begin
    if (rst) begin
      status_reg <= 2'h0;
      ent0_reg <= {W{1'b0}};
      ent1_reg <= {W{1'b0}};
      flag_set <= 1'b0;
    end else begin
      flag_set <= cap_evt && (status_reg != 2'h0);
      if (cap_evt) begin
        case (status_reg)
          2'h0: begin
            ent0_reg <= stamp;
            status_reg <= 2'h1;
          end
          2'h1: begin
            ent1_reg <= stamp;
            status_reg <= 2'h2;
          end
          default: begin
            ent0_reg <= ent1_reg;
            ent1_reg <= stamp;
            status_reg <= 2'h3;
          end
        endcase
      end else if (st_we) begin
        status_reg <= st_wdata;
      end else if (pop && status_reg != 2'h0) begin
        ent0_reg <= ent1_reg;
        status_reg <= (status_reg == 2'h1) ? 2'h0 : 2'h1;
      end
    end
  end
endmodule // mem_capture_queue
`default_nettype wire

// [rtl/mem_top.v]
// Motion event manager: timers, PWM compare, capture, decoder, flags
`timescale 1ns/1ps
`default_nettype none
`include "mem_consts.vh"
module mem_top #(
  parameter W = 16
) (
  input wire clk,
  input wire rst,
  input wire sel,
  input wire [5:0] addr,
  input wire wr,
  input wire rd,
  input wire [15:0] wdata,
  output reg [15:0] rdata_reg,
  input wire [2:0] cap_pin,
  input wire drive_fault_input_n,
  input wire tdir_pin,
  output reg [5:0] pwm_out_reg,
  output reg [5:0] pwm_oe_reg,
  output reg [1:0] tcmp_out_reg,
  output reg [1:0] tcmp_oe_reg,
  output reg irq_reg,
  output reg adc_start_reg
);
  // ----------------------------------------
  // Pin synchronisers (three stages)
  // ----------------------------------------
  reg [3:0] s1_reg, s2_reg, s3_reg;
  wire [3:0] pin_in = {drive_fault_input_n, cap_pin};
  always @(posedge clk) begin
    if (rst) begin
      s1_reg <= 4'hf;
      s2_reg <= 4'hf;
      s3_reg <= 4'hf;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  reg [3:0] q_reg; // Qualified levels
  reg [3:0] qd_reg;
  reg tdir_s1_reg, tdir_s2_reg, tdir_s3_reg, tdir_q_reg;
  always @(posedge clk) begin
    if (rst) begin
      q_reg <= 4'hf;
      qd_reg <= 4'hf;
      tdir_s1_reg <= 1'b0;
      tdir_s2_reg <= 1'b0;
      tdir_s3_reg <= 1'b0;
      tdir_q_reg <= 1'b0;
    end else begin
      q_reg <= (s2_reg & s3_reg) | (q_reg & (s2_reg ^ s3_reg));
      qd_reg <= q_reg;
      tdir_s1_reg <= tdir_pin;
      tdir_s2_reg <= tdir_s1_reg;
      tdir_s3_reg <= tdir_s2_reg;
      if (tdir_s2_reg == tdir_s3_reg)
        tdir_q_reg <= tdir_s3_reg;
    end
  end
  wire [2:0] cap_rise = q_reg[2:0] & ~qd_reg[2:0];
  wire fault_fall = ~q_reg[3] & qd_reg[3];

  // ----------------------------------------
  // Register write strobes
  // ----------------------------------------
  wire we = sel && wr;
  reg [15:0] tcon_reg;
  reg [15:0] tctl_reg [0:1];
  reg [15:0] tper_reg [0:1];
  reg [15:0] tcmp_reg [0:1];
  reg [15:0] tcnt_reg [0:1];
  reg tup_reg [0:1];
  reg [15:0] cmpctl_reg;
  reg [15:0] cmpv_reg [0:2];
  reg [7:0] dbctl_reg;
  reg [1:0] capctl_reg;
  reg [7:0] iflag_reg;
  reg [7:0] imask_reg;
  reg [15:0] qcnt_reg;
  reg [1:0] qprev_reg;

  // Configuration registers; one write sets compare control fully
  always @(posedge clk) begin
    if (rst) begin
      tcon_reg <= 16'h0000;
      cmpctl_reg <= 16'h0000;
      dbctl_reg <= 8'h00;
      capctl_reg <= 2'h0;
      imask_reg <= `MEM_IMASK_RST;
    end else if (we) begin
      if (addr == `MEM_A_TCON) tcon_reg <= wdata;
      else if (addr == `MEM_A_CMPCTL) cmpctl_reg <= wdata;
      else if (addr == `MEM_A_DBCTL) dbctl_reg <= {wdata[11:8], wdata[4:2], 1'b0};
      else if (addr == `MEM_A_CAPCTL) capctl_reg <= wdata[1:0];
      else if (addr == `MEM_A_IMASK) imask_reg <= wdata[7:0];
    end
  end

  // ----------------------------------------
  // Two general purpose timers
  // ----------------------------------------
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_tmr
      wire [5:0] a_cnt = (t == 0) ? `MEM_A_T1CNT : `MEM_A_T2CNT;
      wire [1:0] mode = tctl_reg[t][`MEM_T_MODE_LSB+1:`MEM_T_MODE_LSB];
      wire run = tctl_reg[t][`MEM_T_EN_BIT];
      // Decoder clocks timer 2 only; timer 1 runs on device clock
      wire quadrature_decoder = (t == 1) && tctl_reg[t][`MEM_T_QEP_BIT];
      wire step = quadrature_decoder ? (q_reg[0] != qd_reg[0]) : 1'b1;
      wire dir_up = quadrature_decoder ? (q_reg[0] ^ qd_reg[1]) : tdir_q_reg;
      wire at_top = (tcnt_reg[t] == tper_reg[t]) || (tcnt_reg[t] == 16'hffff);
      wire at_bot = (tcnt_reg[t] == 16'h0000);
      always @(posedge clk) begin
        if (rst) begin
          tctl_reg[t] <= 16'h0000;
          tper_reg[t] <= 16'h0000;
          tcmp_reg[t] <= 16'h0000;
          tcnt_reg[t] <= 16'h0000;
          tup_reg[t] <= 1'b1;
        end else if (we && addr == a_cnt) begin
          tcnt_reg[t] <= wdata;
        end else begin
          if (we && addr == a_cnt + 6'h1) tcmp_reg[t] <= wdata;
          if (we && addr == a_cnt + 6'h2) tper_reg[t] <= wdata;
          // Bit 13 (old third mode bit) reserved
          if (we && addr == a_cnt + 6'h3) tctl_reg[t] <= wdata & 16'hdfff;
          if (run && step) begin
            case (mode)
              `MEM_MODE_CONT_UP: tcnt_reg[t] <= at_top ? 16'h0000 : tcnt_reg[t] + 16'h1;
              `MEM_MODE_CONT_UD, `MEM_MODE_DIR_UD: begin
                // Reverse at end points rather than hold
                if (mode == `MEM_MODE_DIR_UD && !quadrature_decoder && tup_reg[t] != dir_up)
                  tup_reg[t] <= dir_up;
                else if (tup_reg[t] && at_top) begin
                  tup_reg[t] <= 1'b0;
                  tcnt_reg[t] <= tcnt_reg[t] - 16'h1;
                end else if (!tup_reg[t] && at_bot) begin
                  tup_reg[t] <= 1'b1;
                  tcnt_reg[t] <= tcnt_reg[t] + 16'h1;
                end else if (quadrature_decoder && (mode == `MEM_MODE_DIR_UD))
                  tcnt_reg[t] <= dir_up ? tcnt_reg[t] + 16'h1 : tcnt_reg[t] - 16'h1;
                else
                  tcnt_reg[t] <= tup_reg[t] ? tcnt_reg[t] + 16'h1 : tcnt_reg[t] - 16'h1;
              end
              default: tcnt_reg[t] <= tcnt_reg[t];
            endcase
          end
        end
      end
    end
  endgenerate
  // Two separate 16-bit timers, never chained

  // ----------------------------------------
  // PWM compare units with dead band
  // ----------------------------------------
  reg [4:0] ps_cnt_reg;
  wire [2:0] ps_sel = dbctl_reg[3:1];
  wire [5:0] ps_div = 6'h01 << ps_sel;
  // Unused select codes fall back to the slowest ratio
  wire ps_tick = ({1'b0, ps_cnt_reg} == ps_div - 6'h1) || (ps_div == 6'h00 && ps_cnt_reg == 5'h1f);
  always @(posedge clk) begin
    if (rst)
      ps_cnt_reg <= 5'h00;
    else
      ps_cnt_reg <= ps_tick ? 5'h00 : ps_cnt_reg + 5'h1;
  end
  wire [3:0] db_period = dbctl_reg[7:4];
  wire [5:0] pwm_raw;
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_cmp
      reg [3:0] db_cnt_reg;
      reg lvl_reg;
      wire lvl = cmpctl_reg[`MEM_CMP_EN_BIT] && (tcnt_reg[0] < cmpv_reg[c]);
      always @(posedge clk) begin
        if (rst) begin
          cmpv_reg[c] <= 16'h0000;
          db_cnt_reg <= 4'h0;
          lvl_reg <= 1'b0;
        end else begin
          if (we && addr == `MEM_A_CMP1 + c) cmpv_reg[c] <= wdata;
          lvl_reg <= lvl;
          if (lvl != lvl_reg)
            db_cnt_reg <= db_period;
          else if (ps_tick && db_cnt_reg != 4'h0)
            db_cnt_reg <= db_cnt_reg - 4'h1;
        end
      end
      // Pair outputs, both off while the dead band runs
      assign pwm_raw[2*c] = lvl_reg && (db_cnt_reg == 4'h0);
      assign pwm_raw[2*c+1] = !lvl_reg && (db_cnt_reg == 4'h0);
    end
  endgenerate

  // ----------------------------------------
  // Capture units and queues
  // ----------------------------------------
  wire [15:0] tbase = capctl_reg[`MEM_CAP_TB_BIT] ? tcnt_reg[0] : tcnt_reg[1];
  wire [1:0] qst [0:2];
  wire [15:0] qe0 [0:2];
  wire [15:0] qe1 [0:2];
  wire [2:0] qflag;
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_cap
      mem_capture_queue #(.W(16)) u_q (
        .clk(clk),
        .rst(rst),
        .cap_evt(cap_rise[k]),
        .stamp(tbase),
        .pop(sel && rd && addr == `MEM_A_CAPE0 + 2 * k),
        .st_we(we && addr == `MEM_A_CAPQ),
        .st_wdata(wdata[2*k+7:2*k+6]),
        .status_reg(qst[k]),
        .ent0_reg(qe0[k]),
        .ent1_reg(qe1[k]),
        .flag_set(qflag[k])
      );
    end
  endgenerate

  // ----------------------------------------
  // Flags, request and outputs
  // ----------------------------------------
  wire [7:0] fl_set = {qflag, 4'h0, fault_fall}; // Capture flags at bits 5..7
  wire [7:0] fl_clr = (we && addr == `MEM_A_IFLAG) ? wdata[7:0] : 8'h00;
  always @(posedge clk) begin
    if (rst) begin
      iflag_reg <= 8'h00;
      irq_reg <= 1'b0;
      adc_start_reg <= 1'b0;
      pwm_out_reg <= 6'h00;
      pwm_oe_reg <= 6'h00;
      tcmp_out_reg <= 2'h0;
      tcmp_oe_reg <= 2'h0;
    end else begin
      iflag_reg <= (iflag_reg & ~fl_clr) | fl_set;
      irq_reg <= |(iflag_reg & imask_reg);
      adc_start_reg <= cap_rise[2] && capctl_reg[`MEM_CAP_ADC_BIT];
      pwm_out_reg <= pwm_raw;
      tcmp_out_reg <= {tcnt_reg[1] < tcmp_reg[1], tcnt_reg[0] < tcmp_reg[0]};
      // Fault pin low or latched flag tristates everything when unmasked
      if (imask_reg[`MEM_FLAG_FAULT] && (!s2_reg[3] || iflag_reg[`MEM_FLAG_FAULT])) begin
        pwm_oe_reg <= 6'h00;
        tcmp_oe_reg <= 2'h0;
      end else begin
        pwm_oe_reg <= {6{cmpctl_reg[`MEM_CMP_EN_BIT]}};
        tcmp_oe_reg <= {tctl_reg[1][1], tctl_reg[0][1]};
      end
    end
  end

  // Read mux; vector reads never touch flags
  always @(posedge clk) begin
    if (rst)
      rdata_reg <= 16'h0000;
    else if (sel && rd) begin
      if (addr == `MEM_A_TCON) rdata_reg <= tcon_reg;
      else if (addr == `MEM_A_T1CNT) rdata_reg <= tcnt_reg[0];
      else if (addr == `MEM_A_T1CMP) rdata_reg <= tcmp_reg[0];
      else if (addr == `MEM_A_T1PR) rdata_reg <= tper_reg[0];
      else if (addr == `MEM_A_T1CTL) rdata_reg <= tctl_reg[0];
      else if (addr == `MEM_A_T2CNT) rdata_reg <= tcnt_reg[1];
      else if (addr == `MEM_A_T2CMP) rdata_reg <= tcmp_reg[1];
      else if (addr == `MEM_A_T2PR) rdata_reg <= tper_reg[1];
      else if (addr == `MEM_A_T2CTL) rdata_reg <= tctl_reg[1];
      else if (addr == `MEM_A_CMPCTL) rdata_reg <= cmpctl_reg;
      else if (addr == `MEM_A_DBCTL) rdata_reg <= {4'h0, dbctl_reg[7:4], 3'h0, dbctl_reg[3:2], dbctl_reg[1], 2'h0};
      else if (addr == `MEM_A_CMP1) rdata_reg <= cmpv_reg[0];
      else if (addr == `MEM_A_CMP2) rdata_reg <= cmpv_reg[1];
      else if (addr == `MEM_A_CMP3) rdata_reg <= cmpv_reg[2];
      else if (addr == `MEM_A_CAPCTL) rdata_reg <= {14'h0000, capctl_reg};
      else if (addr == `MEM_A_CAPQ) rdata_reg <= {4'h0, qst[2], qst[1], qst[0], 6'h00};
      else if (addr == `MEM_A_CAPE0) rdata_reg <= qe0[0];
      else if (addr == `MEM_A_CAPE0 + 6'h1) rdata_reg <= qe1[0];
      else if (addr == `MEM_A_CAPE0 + 6'h2) rdata_reg <= qe0[1];
      else if (addr == `MEM_A_CAPE0 + 6'h3) rdata_reg <= qe1[1];
      else if (addr == `MEM_A_CAPE0 + 6'h4) rdata_reg <= qe0[2];
      else if (addr == `MEM_A_CAPE0 + 6'h5) rdata_reg <= qe1[2];
      else if (addr == `MEM_A_IFLAG) rdata_reg <= {8'h00, iflag_reg};
      else if (addr == `MEM_A_IMASK) rdata_reg <= {8'h00, imask_reg};
      else rdata_reg <= 16'h0000;
    end
  end
  // Device-wide block list
endmodule // mem_top
`default_nettype wire

// [verif/mem_top_chk.sv]
// Port-level checker for the motion event manager
`timescale 1ns/1ps
`default_nettype none
module mem_top_chk #(
  parameter W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel,
  input wire logic [5:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata_reg,
  input wire logic drive_fault_input_n,
  input wire logic [5:0] pwm_oe_reg,
  input wire logic [1:0] tcmp_oe_reg,
  input wire logic irq_reg,
  input wire logic adc_start_reg
);
  // Fault mask bit followed from bus writes
  logic mask_b0_reg;
  logic mask_b0_next;
  assign mask_b0_next = (sel && wr && addr == 6'h2c) ? wdata[0] : mask_b0_reg;
  always_ff @(posedge clk) begin
    mask_b0_reg <= rst ? 1'b1 : mask_b0_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read strobe on one address
  sequence s_rd(logic [5:0] a);
    sel && rd && addr == a;
  endsequence
  property p_rst_out;
    disable iff (1'b0) rst |=> irq_reg == 1'b0 && pwm_oe_reg == 6'h00 && adc_start_reg == 1'b0 && rdata_reg == 16'h0000;
  endproperty
  property p_fault_oe;
    (!drive_fault_input_n && mask_b0_reg) [*6] |-> pwm_oe_reg == 6'h00 && tcmp_oe_reg == 2'h0;
  endproperty
  property p_fault_irq;
    (!drive_fault_input_n && mask_b0_reg) [*8] |-> irq_reg;
  endproperty
  property p_rd_stable;
    !(sel && rd) |=> $stable(rdata_reg);
  endproperty
  property p_undef;
    s_rd(6'h3e) |=> rdata_reg == 16'h0000;
  endproperty
  property p_adc_pulse;
    $rose(adc_start_reg) |=> !adc_start_reg;
  endproperty
  property p_db_res;
    s_rd(6'h15) |=> rdata_reg[1:0] == 2'h0 && rdata_reg[15:12] == 4'h0;
  endproperty
  property p_capq_res;
    s_rd(6'h22) |=> rdata_reg[5:0] == 6'h00;
  endproperty
  property p_tctl_res;
    sel && rd && (addr == 6'h04 || addr == 6'h08) |=> !rdata_reg[13];
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  a_fault_oe: assert property (p_fault_oe) else $error("outputs driven during fault");
  a_fault_irq: assert property (p_fault_irq) else $error("no request during fault");
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved without read");
  a_undef: assert property (p_undef) else $error("undefined address not zero");
  a_adc_pulse: assert property (p_adc_pulse) else $error("converter start too long");
  a_db_res: assert property (p_db_res) else $error("dead-band reserved bits set");
  a_capq_res: assert property (p_capq_res) else $error("queue status low bits set");
  a_tctl_res: assert property (p_tctl_res) else $error("legacy mode bit set");
  c_fault: cover property (irq_reg && !drive_fault_input_n);
  c_adc: cover property (adc_start_reg);
  c_entry: cover property (s_rd(6'h24));
endmodule // mem_top_chk
bind mem_top mem_top_chk #(.W(W)) i_chk (.clk(clk), .rst(rst), .sel(sel), .addr(addr), .wr(wr), .rd(rd),
  .wdata(wdata), .rdata_reg(rdata_reg), .drive_fault_input_n(drive_fault_input_n), .pwm_oe_reg(pwm_oe_reg),
  .tcmp_oe_reg(tcmp_oe_reg), .irq_reg(irq_reg), .adc_start_reg(adc_start_reg));
`default_nettype wire

// [verif/mem_drive_model.sv]
// Power stage and encoder model at the motion event manager pins
`timescale 1ns/1ps
`default_nettype none
module mem_drive_model (
  input wire logic clk,
  input wire logic [5:0] pwm_oe,
  input wire logic [1:0] tcmp_oe,
  output var logic [2:0] cap_pin,
  output var logic fault_n
);
  // Stage inputs left floating when not driven
  wire [7:0] stage_float = ~{tcmp_oe, pwm_oe};
  // Idle pins: no edges, no fault
  initial begin
    cap_pin = 3'h0;
    fault_n = 1'b1;
  end
  // One capture edge, held long enough for the synchroniser
  task automatic pulse(input int k);
    @(posedge clk);
    #1 cap_pin[k] = 1'b1;
    repeat (12) @(posedge clk);
    #1 cap_pin[k] = 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // Fault line, active low
  task automatic set_fault(input logic v);
    @(posedge clk);
    #1 fault_n = v;
  endtask
endmodule // mem_drive_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the motion event manager
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic tdir = 1'b0;
  logic [15:0] d;
  wire [15:0] rdata_reg;
  wire [2:0] cap_pin;
  wire fault_n;
  wire [5:0] pwm_out_reg;
  wire [5:0] pwm_oe_reg;
  wire [1:0] tcmp_out_reg;
  wire [1:0] tcmp_oe_reg;
  wire irq_reg;
  wire adc_start_reg;
  int bad_count = 0;
  int total_checks = 0;
  int adc_seen = 0;
  // Clock and converter start counter
  always #2 clk = ~clk;
  always @(posedge clk) if (adc_start_reg === 1'b1) adc_seen++;
  mem_top #(.W(16)) i_dut (.clk(clk), .rst(rst), .sel(sel), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
    .rdata_reg(rdata_reg), .cap_pin(cap_pin), .drive_fault_input_n(fault_n), .tdir_pin(tdir),
    .pwm_out_reg(pwm_out_reg), .pwm_oe_reg(pwm_oe_reg), .tcmp_out_reg(tcmp_out_reg),
    .tcmp_oe_reg(tcmp_oe_reg), .irq_reg(irq_reg), .adc_start_reg(adc_start_reg));
  mem_drive_model i_drv (.clk(clk), .pwm_oe(pwm_oe_reg), .tcmp_oe(tcmp_oe_reg), .cap_pin(cap_pin),
    .fault_n(fault_n));
  // Bus cycles and comparison
  task automatic wr_reg(input logic s, input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    #1 sel = s;
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(posedge clk);
    #1 sel = 1'b0;
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a);
    @(posedge clk);
    #1 sel = 1'b1;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 sel = 1'b0;
    rd = 1'b0;
    d = rdata_reg;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      $display("wrong value at %0t: %s", $time, m);
      bad_count++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    rd_reg(6'h2c);
    chk(d, 16'h0001, "mask after reset");
    wr_reg(1'b1, 6'h3e, 16'hffff);
    rd_reg(6'h3e);
    chk(d, 16'h0000, "undefined address");
    wr_reg(1'b0, 6'h15, 16'h001c);
    rd_reg(6'h15);
    chk(d, 16'h0000, "write without select");
    $display("reset test done");
  endtask
  task automatic t_regs;
    wr_reg(1'b1, 6'h15, 16'hffff);
    rd_reg(6'h15);
    chk(d, 16'h0f1c, "dead-band fields");
    wr_reg(1'b1, 6'h04, 16'h3800);
    rd_reg(6'h04);
    chk(d & 16'h3800, 16'h1800, "timer mode field");
    wr_reg(1'b1, 6'h22, 16'h0fff);
    rd_reg(6'h22);
    chk(d, 16'h0fc0, "queue status");
    wr_reg(1'b1, 6'h22, 16'h0000);
    wr_reg(1'b1, 6'h04, 16'h0000);
    wr_reg(1'b1, 6'h15, 16'h0000);
    $display("register test done");
  endtask
  task automatic t_capture;
    wr_reg(1'b1, 6'h20, 16'h0001);
    wr_reg(1'b1, 6'h01, 16'h1234);
    i_drv.pulse(0);
    rd_reg(6'h2f);
    chk(d & 16'h0020, 16'h0000, "flag on first capture");
    wr_reg(1'b1, 6'h01, 16'h5678);
    i_drv.pulse(0);
    rd_reg(6'h2f);
    chk(d & 16'h0020, 16'h0020, "flag on second capture");
    rd_reg(6'h24);
    chk(d, 16'h5678, "newer entry");
    rd_reg(6'h23);
    chk(d, 16'h1234, "older entry");
    wr_reg(1'b1, 6'h2c, 16'h0021);
    idle(3);
    chk({15'h0000, irq_reg}, 16'h0001, "capture request");
    wr_reg(1'b1, 6'h2f, 16'h0000);
    rd_reg(6'h2f);
    rd_reg(6'h2f);
    chk(d & 16'h0020, 16'h0020, "flag kept");
    wr_reg(1'b1, 6'h2f, 16'h0020);
    idle(3);
    chk({15'h0000, irq_reg}, 16'h0000, "request after clear");
    wr_reg(1'b1, 6'h2c, 16'h0001);
    wr_reg(1'b1, 6'h20, 16'h0002);
    wr_reg(1'b1, 6'h05, 16'h0777);
    i_drv.pulse(2);
    rd_reg(6'h27);
    chk(d, 16'h0777, "timer 2 base");
    chk(adc_seen[15:0], 16'h0001, "converter start");
    $display("capture test done");
  endtask
  task automatic t_fault;
    wr_reg(1'b1, 6'h03, 16'h0010);
    wr_reg(1'b1, 6'h11, 16'h8000);
    wr_reg(1'b1, 6'h04, 16'h0842);
    idle(20);
    i_drv.set_fault(1'b0);
    idle(10);
    chk({8'h00, tcmp_oe_reg, pwm_oe_reg}, 16'h0000, "outputs released");
    chk({15'h0000, irq_reg}, 16'h0001, "fault request");
    rd_reg(6'h2f);
    chk(d & 16'h0001, 16'h0001, "fault flag");
    i_drv.set_fault(1'b1);
    idle(8);
    wr_reg(1'b1, 6'h2f, 16'h0001);
    idle(3);
    chk({15'h0000, irq_reg}, 16'h0000, "fault cleared");
    $display("fault test done");
  endtask
  task automatic t_timer;
    wr_reg(1'b1, 6'h07, 16'h0021);
    wr_reg(1'b1, 6'h05, 16'h0010);
    wr_reg(1'b1, 6'h08, 16'h1840);
    idle(60);
    rd_reg(6'h05);
    chk(d & 16'hfffe, 16'h0000, "down count turns at zero");
    @(posedge clk);
    #1 tdir = 1'b1;
    idle(120);
    rd_reg(6'h05);
    chk(d | 16'h0001, 16'h0021, "up count turns at period");
    wr_reg(1'b1, 6'h08, 16'h0000);
    $display("timer test done");
  endtask
  task automatic t_pwm;
    wr_reg(1'b1, 6'h11, 16'h8000);
    wr_reg(1'b1, 6'h04, 16'h0002);
    wr_reg(1'b1, 6'h01, 16'h0100);
    wr_reg(1'b1, 6'h17, 16'hffff);
    idle(4);
    chk({10'h000, pwm_out_reg}, 16'h0029, "pwm pair levels");
    wr_reg(1'b1, 6'h15, 16'h0f00);
    wr_reg(1'b1, 6'h17, 16'h0000);
    idle(2);
    chk({14'h0000, pwm_out_reg[1:0]}, 16'h0000, "dead band gap");
    idle(20);
    chk({14'h0000, pwm_out_reg[1:0]}, 16'h0002, "dead band end");
    wr_reg(1'b1, 6'h15, 16'h0000);
    $display("pwm test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    idle(16);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_capture();
    t_fault();
    t_timer();
    t_pwm();
    stop_test();
  end
  // Watchdog
  initial begin
    #40000;
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
